// file: include/tx_checksum_offload_defs.vh
`ifndef TX_CHECKSUM_OFFLOAD_DEFS_VH
`define TX_CHECKSUM_OFFLOAD_DEFS_VH

// Register byte addresses
`define TXCO_CTRL_ADDR      8'h00
`define TXCO_STATUS_ADDR    8'h04
`define TXCO_SUM_ADDR       8'h08

// Control register fields and reset value
`define TXCO_CTRL_ENABLE    0
`define TXCO_CTRL_MODE      1
`define TXCO_CTRL_RESET     2'h0

// Preamble word fields
`define TXCO_LOC_MSB        27
`define TXCO_LOC_LSB        16
`define TXCO_START_MSB      11
`define TXCO_START_LSB      0

// Command word flag positions
`define TXCO_CMDA_FIRST_SEG 13
`define TXCO_CMDB_SUM_REQ   14

// Frame store depth in 32-bit words
`define TXCO_FRAME_WORDS    512
`define TXCO_FRAME_AW       9

`endif

// file: rtl/ones_sum_accum.v
module ones_sum_accum (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        clear,
   input  wire        add_en,
   input  wire [17:0] addend,
   output wire [15:0] sum
);

   reg  [15:0] acc;
   wire [18:0] total;
   wire [16:0] fold1;
   wire [15:0] fold2;

   // Carries out of bit 15 wrap back into bit 0
   assign total = {3'h0, acc} + {1'h0, addend};
   assign fold1 = {14'h0, total[18:16]} + {1'h0, total[15:0]};
   assign fold2 = fold1[15:0] + {15'h0, fold1[16]};
   assign sum   = acc;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= 16'h0000;
      end else if (clear) begin
         acc <= 16'h0000;
      end else if (add_en) begin
         acc <= fold2;
      end
   end

endmodule // ones_sum_accum

// file: rtl/tx_checksum_offload.v
`include "tx_checksum_offload_defs.vh"

module tx_checksum_offload #(
   parameter DEPTH = `TXCO_FRAME_WORDS,
   parameter AW    = `TXCO_FRAME_AW
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output reg  [31:0] hrdata,
   output wire        hresp,
   input  wire        in_valid,
   output wire        in_ready,
   input  wire [31:0] in_data,
   input  wire        in_last,
   input  wire [1:0]  in_bytes,
   output reg         out_valid,
   input  wire        out_ready,
   output reg  [31:0] out_data,
   output reg         out_last,
   output reg  [1:0]  out_bytes
);

   localparam [2:0] ST_CMDA  = 3'h0;
   localparam [2:0] ST_CMDB  = 3'h1;
   localparam [2:0] ST_PRE   = 3'h2;
   localparam [2:0] ST_STORE = 3'h3;
   localparam [2:0] ST_SEND  = 3'h4;

   reg  [31:0] mem [0:DEPTH-1];
   reg  [2:0]  state;
   reg  [31:0] cmd_a;
   reg  [31:0] cmd_b;
   reg         pkt_enable;
   reg         calc;
   reg  [11:0] insert_offset;
   reg  [11:0] sum_start_offset;
   reg  [AW:0] wcnt;
   reg  [1:0]  last_bytes;
   reg  [AW+1:0] sidx;
   reg         offload_enable;
   reg         offload_mode_select;
   reg  [15:0] last_sum;
   reg  [7:0]  frame_count;
   reg         wr_pend;
   reg  [7:0]  wr_addr;
   wire [15:0] acc_sum;
   wire [15:0] final_sum;
   wire        take;
   wire        addr_phase;
   wire [3:0]  in_mask;
   wire        out_free;
   wire [AW:0] word_idx;
   reg  [31:0] next_data;

   // Bytes of a word present in the frame: 0 encodes four
   function [3:0] byte_mask;
      input       last;
      input [1:0] cnt;
      begin
         if (!last || cnt == 2'h0) begin
            byte_mask = 4'hF;
         end else if (cnt == 2'h1) begin
            byte_mask = 4'h1;
         end else if (cnt == 2'h2) begin
            byte_mask = 4'h3;
         end else begin
            byte_mask = 4'h7;
         end
      end
   endfunction

   // Contribution of one word's bytes at or after the start offset
   function [17:0] byte_term;
      input [31:0] word;
      input [AW:0] widx;
      input [11:0] start;
      input [3:0]  mask;
      reg   [13:0] off;
      integer      k;
      begin
         byte_term = 18'h00000;
         for (k = 0; k < 4; k = k + 1) begin
            off = {{(11-AW){1'b0}}, widx, 2'h0} + k[13:0];
            if (mask[k] && off >= {2'h0, start}) begin
               if (off[0] ^ start[0]) begin
                  byte_term = byte_term +
                              {2'h0, word[8*k +: 8], 8'h00};
               end else begin
                  byte_term = byte_term +
                              {10'h000, word[8*k +: 8]};
               end
            end
         end
      end
   endfunction

   // Overlay checksum bytes onto a stored word
   function [31:0] insert_sum;
      input [31:0] word;
      input [AW:0] widx;
      input [11:0] loc;
      input [15:0] cs;
      reg   [13:0] off;
      integer      k;
      begin
         insert_sum = word;
         for (k = 0; k < 4; k = k + 1) begin
            off = {{(11-AW){1'b0}}, widx, 2'h0} + k[13:0];
            if (off == {2'h0, loc}) begin
               insert_sum[8*k +: 8] = cs[7:0];
            end else if (off == {2'h0, loc} + 14'h0001) begin
               insert_sum[8*k +: 8] = cs[15:8];
            end
         end
      end
   endfunction

   assign in_ready  = (state == ST_CMDA) || (state == ST_CMDB) ||
                      (state == ST_PRE) || (state == ST_STORE);
   assign take      = in_valid && in_ready;
   assign in_mask   = byte_mask(in_last, in_bytes);
   assign final_sum = ~acc_sum;
   assign out_free  = !out_valid || out_ready;
   assign word_idx  = sidx[AW:0] - {{AW{1'b0}}, 1'b1} - {{AW{1'b0}}, 1'b1};

   ones_sum_accum u_sum (
      .clk    (hclk),
      .rst_n  (hresetn),
      .clear  (state == ST_CMDA),
      .add_en (take && state == ST_STORE && calc),
      .addend (byte_term(in_data, wcnt, sum_start_offset, in_mask)),
      .sum    (acc_sum)
   );

   always @(posedge hclk) begin
      if (take && state == ST_STORE && wcnt < DEPTH) begin
         mem[wcnt[AW-1:0]] <= in_data;
      end
   end

   always @* begin
      if (sidx == {(AW+2){1'b0}}) begin
         next_data = cmd_a;
      end else if (sidx == {{(AW+1){1'b0}}, 1'b1}) begin
         next_data = cmd_b;
      end else if (calc) begin
         next_data = insert_sum(mem[word_idx[AW-1:0]], word_idx,
                                insert_offset, final_sum);
      end else begin
         next_data = mem[word_idx[AW-1:0]];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state            <= ST_CMDA;
         cmd_a            <= 32'h00000000;
         cmd_b            <= 32'h00000000;
         pkt_enable       <= 1'b0;
         calc             <= 1'b0;
         insert_offset    <= 12'h000;
         sum_start_offset <= 12'h000;
         wcnt             <= {(AW+1){1'b0}};
         last_bytes       <= 2'h0;
         sidx             <= {(AW+2){1'b0}};
         last_sum         <= 16'h0000;
         frame_count      <= 8'h00;
         out_valid        <= 1'b0;
         out_data         <= 32'h00000000;
         out_last         <= 1'b0;
         out_bytes        <= 2'h0;
      end else begin
         if (out_valid && out_ready) begin
            out_valid <= 1'b0;
         end
         case (state)
            ST_CMDA: begin
               wcnt <= {(AW+1){1'b0}};
               sidx <= {(AW+2){1'b0}};
               if (take) begin
                  cmd_a      <= in_data;
                  pkt_enable <= offload_enable;
                  state      <= ST_CMDB;
               end
            end
            ST_CMDB: begin
               if (take) begin
                  cmd_b <= in_data;
                  calc  <= offload_enable &&
                           cmd_a[`TXCO_CMDA_FIRST_SEG] &&
                           in_data[`TXCO_CMDB_SUM_REQ];
                  state <= pkt_enable ? ST_PRE : ST_STORE;
               end
            end
            ST_PRE: begin
               if (take) begin
                  insert_offset    <= in_data[`TXCO_LOC_MSB:`TXCO_LOC_LSB];
                  sum_start_offset <= in_data[`TXCO_START_MSB:`TXCO_START_LSB];
                  state            <= ST_STORE;
               end
            end
            ST_STORE: begin
               if (take) begin
                  if (wcnt < DEPTH) begin
                     wcnt <= wcnt + {{AW{1'b0}}, 1'b1};
                  end
                  if (in_last) begin
                     last_bytes <= in_bytes;
                     state      <= ST_SEND;
                  end
               end
            end
            ST_SEND: begin
               if (out_free) begin
                  out_valid <= 1'b1;
                  out_data  <= next_data;
                  out_bytes <= 2'h0;
                  out_last  <= 1'b0;
                  sidx      <= sidx + {{(AW+1){1'b0}}, 1'b1};
                  if (word_idx == wcnt - {{AW{1'b0}}, 1'b1} &&
                      sidx > {{AW{1'b0}}, 2'h1}) begin
                     out_last    <= 1'b1;
                     out_bytes   <= last_bytes;
                     last_sum    <= calc ? final_sum : 16'h0000;
                     frame_count <= frame_count + 8'h01;
                     state       <= ST_CMDA;
                  end
               end
            end
            default: begin
               state <= ST_CMDA;
            end
         endcase
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign addr_phase = hsel && htrans[1] && hready;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend             <= 1'b0;
         wr_addr             <= 8'h00;
         hrdata              <= 32'h00000000;
         offload_enable      <= 1'b0;
         offload_mode_select <= 1'b0;
      end else begin
         if (wr_pend && wr_addr == `TXCO_CTRL_ADDR) begin
            offload_enable      <= hwdata[`TXCO_CTRL_ENABLE];
            offload_mode_select <= hwdata[`TXCO_CTRL_MODE];
         end
         if (hready) begin
            wr_pend <= addr_phase && hwrite;
            wr_addr <= haddr[7:0];
         end
         if (addr_phase && !hwrite) begin
            case (haddr[7:0])
               `TXCO_CTRL_ADDR: begin
                  hrdata <= {30'h00000000, offload_mode_select,
                             offload_enable};
               end
               `TXCO_STATUS_ADDR: begin
                  hrdata <= {20'h00000, frame_count, calc,
                             state};
               end
               `TXCO_SUM_ADDR: begin
                  hrdata <= {16'h0000, last_sum};
               end
               default: begin
                  hrdata <= 32'h00000000;
               end
            endcase
         end
      end
   end

endmodule // tx_checksum_offload

// file: sim/mac_sink.sv
module mac_sink (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        out_valid,
   input  wire logic [31:0] out_data,
   input  wire logic        out_last,
   input  wire logic [1:0]  out_bytes,
   output logic             out_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] got[$];
   logic [2:0]  ends[$];
   // Collects taken words and end marks, stalls about one cycle in four
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_ready <= 1'b0;
      end else begin
         if (out_valid && out_ready) begin
            got.push_back(out_data);
            ends.push_back({out_last, out_bytes});
         end
         out_ready <= ($urandom % 4) != 0;
      end
   end
endmodule // mac_sink

// file: sim/tx_checksum_offload_assertions.sv
module tx_checksum_offload_checker #(
   parameter DEPTH = 512,
   parameter AW    = 9
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        in_valid,
   input wire logic        in_ready,
   input wire logic        in_last,
   input wire logic        out_valid,
   input wire logic        out_ready,
   input wire logic [31:0] out_data,
   input wire logic        out_last,
   input wire logic [1:0]  out_bytes
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic lst = in_valid && in_ready && in_last;
   property p_hold;
      out_valid && !out_ready |=> out_valid && $stable(out_data);
   endproperty
   a_hold: assert property (p_hold) else $error("word lost");
   property p_store; out_valid && !out_last |-> !in_ready; endproperty
   a_store: assert property (p_store) else $error("input open");
   property p_lastblk; lst |=> !in_ready; endproperty
   a_lastblk: assert property (p_lastblk) else $error("in open");
   property p_start; lst |-> ##[1:3] out_valid; endproperty
   a_start: assert property (p_start) else $error("no send");
   property p_bytes; out_valid && !out_last |-> out_bytes == 2'h0; endproperty
   a_bytes: assert property (p_bytes) else $error("bad bytes");
   property p_end; out_valid && out_ready && out_last |=> !out_valid; endproperty
   a_end: assert property (p_end) else $error("extra word");
   property p_rise; $rose(out_valid) |-> $past(!in_ready); endproperty
   a_rise: assert property (p_rise) else $error("early send");
   property p_unmap;
      hsel && htrans[1] && hready && !hwrite && haddr[7:0] == 8'h0C
      |=> hrdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
endmodule // tx_checksum_offload_checker

bind tx_checksum_offload tx_checksum_offload_checker #(.DEPTH(DEPTH), .AW(AW))
   chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .in_valid(in_valid), .in_ready(in_ready), .in_last(in_last),
   .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
   .out_last(out_last), .out_bytes(out_bytes));

// file: sim/tx_checksum_offload_tb.sv
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin \
   error_cnt++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tx_checksum_offload_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, in_valid = 0;
   logic        in_last = 0, in_ready, out_valid, out_ready, out_last;
   logic        hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, in_data = 0, hrdata, out_data, r;
   logic [1:0]  htrans = 0, in_bytes = 0, out_bytes;
   logic [2:0]  hsize = 3'h2;
   wire logic   hready = hreadyout;
   int          error_cnt = 0, total_checks = 0, cyc = 0, frames = 0;
   logic [31:0] exp_q[$];
   logic [7:0]  b[$];
   initial forever #25 hclk = ~hclk;
   tx_checksum_offload dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .in_valid(in_valid),
      .in_ready(in_ready), .in_data(in_data), .in_last(in_last),
      .in_bytes(in_bytes), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .out_last(out_last), .out_bytes(out_bytes));
   mac_sink mac_u (.hclk(hclk), .hresetn(hresetn), .out_valid(out_valid),
      .out_data(out_data), .out_last(out_last), .out_bytes(out_bytes),
      .out_ready(out_ready));
   task summarize;
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic ahb(input logic w, input logic [31:0] a, d,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      `CHK("bus resp", 2'h2, {hreadyout, hresp})
   endtask
   task automatic put(input logic [31:0] w, input logic l,
                      input logic [1:0] n);
      in_valid <= 1; in_data <= w; in_last <= l; in_bytes <= n;
      do @(posedge hclk); while (in_ready !== 1'b1);
   endtask
   task automatic frame(input bit en, fs, ck, zero);
      int len, st, loc, nw;
      logic [31:0] ca, cb, inq[$];
      logic [16:0] s;
      logic [15:0] cs;
      logic [7:0] hi;
      logic [2:0] fin;
      bit calc;
      len = zero ? 30 : 20 + $urandom % 60;
      st = zero ? 14 : 14 + $urandom % (len - 18);
      loc = zero ? 20 : 14 + $urandom % (len - 19);
      b.delete();
      for (int i = 0; i < len; i++) b.push_back(zero ? 8'h0 : 8'($urandom));
      if (zero) begin b[14] = 8'hFF; b[15] = 8'hFF; end
      s = 0;
      for (int i = st; i < len; i += 2) begin
         hi = (i + 1 < len) ? b[i+1] : 8'h00;
         s = {1'b0, s[15:0]} + {1'b0, hi, b[i]};
         s = s[15:0] + s[16];
      end
      cs = ~s[15:0];
      calc = en && fs && ck;
      nw = (len + 3) / 4;
      fin = {1'b1, 2'(len % 4)};
      while (b.size() < 4 * nw) b.push_back(8'h00);
      for (int k = 0; k < nw; k++)
         inq.push_back({b[4*k+3], b[4*k+2], b[4*k+1], b[4*k]});
      if (calc) begin b[loc] = cs[7:0]; b[loc+1] = cs[15:8]; end
      ca = $urandom; ca[13] = fs;
      cb = $urandom;
      cb[14] = ck;
      cb[10:0] = 11'(len + (en ? 4 : 0));
      exp_q = {ca, cb};
      for (int k = 0; k < nw; k++)
         exp_q.push_back({b[4*k+3], b[4*k+2], b[4*k+1], b[4*k]});
      @(posedge hclk);
      put(ca, 0, 0);
      put(cb, 0, 0);
      if (en) put({4'h0, 12'(loc), 4'h0, 12'(st)}, 0, 0);
      for (int k = 0; k < nw; k++) put(inq[k], k == nw - 1, 2'(len % 4));
      in_valid <= 0; in_last <= 0;
      while (mac_u.got.size() < exp_q.size()) @(posedge hclk);
      foreach (exp_q[k]) `CHK("out_data", exp_q[k], mac_u.got[k])
      foreach (exp_q[k])
         `CHK("out_end", k == nw + 1 ? fin : 3'h0, mac_u.ends[k])
      mac_u.got.delete();
      mac_u.ends.delete();
      ahb(0, 32'h08, 0, r);
      `CHK("sum", calc ? {16'h0, cs} : 32'h0, r)
      frames++;
      ahb(0, 32'h04, 0, r);
      `CHK("status", {20'h0, 8'(frames), calc, 3'h0}, r)
   endtask
   initial begin
      void'($urandom(10144));
      repeat (10) @(posedge hclk);
      hresetn <= 1;
      ahb(0, 32'h00, 0, r);
      `CHK("ctrl reset", 32'h0, r)
      ahb(0, 32'h0C, 0, r);
      `CHK("unmapped", 32'h0, r)
      ahb(1, 32'h00, 32'h3, r);
      ahb(0, 32'h00, 0, r);
      `CHK("ctrl", 32'h3, r)
      for (int t = 0; t < 10; t++) begin
         if (t == 7) ahb(1, 32'h00, 32'h0, r);
         frame(t < 7, t != 5, t > 6 ? $urandom % 2 : t != 4,
               t == 6);
      end
      summarize();
   end
endmodule // tx_checksum_offload_tb
